// file: rxcfg_pkg.sv
package rxcfg_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam int ADDR_W = 6;
   localparam logic [ADDR_W-1:0] AUX_DEF_ADDR = 6'h09;
   localparam logic [ADDR_W-1:0] RX_CFG1_ADDR = 6'h0A;
   localparam logic [ADDR_W-1:0] RX_CFG2_ADDR = 6'h0B;
   localparam logic [7:0]        UNMAPPED_VAL = 8'h00;

   // ****************************************
   // Field layouts
   // ****************************************
   typedef struct packed {
      logic       rx_without_crc;
      logic       crc_into_fifo;
      logic       tx_modulation_select;
      logic       ext_field_detect_enable;
      logic       driver_tristate_on_keying;
      logic       rx_tolerant;
      logic       field_on_n_hi;
      logic       field_on_n_lo;
   } rxcfg_aux_type;

   typedef struct packed {
      logic       rx_channel_select;
      logic       am_demod_mixer;
      logic [2:0] lowpass_code;
      logic [2:0] zero_setting;
   } rxcfg_rx1_type;

   typedef struct packed {
      logic       receiver_low_power;
      logic       lowfreq_split_inputs;
      logic       lowfreq_on_input;
      logic       agc_enable;
      logic       agc_full_period;
      logic       agc_reset_alg;
      logic       auto_squelch;
      logic       pm_mixer_clock_source;
   } rxcfg_rx2_type;

   localparam rxcfg_aux_type AUX_DEFAULT = 8'h04;
   localparam rxcfg_rx1_type RX1_DEFAULT = 8'h00;
   localparam rxcfg_rx2_type RX2_DEFAULT = 8'h1A;

   // ****************************************
   // Timing
   // ****************************************
   localparam int  CLK_HZ          = 10_000_000;
   localparam real SQ_DELAY_US     = 18.88;
   localparam real CARRIER_HZ      = 13.56e6;
   localparam int  MRT_STEP_FC     = 64;
   localparam int  MRT_MIN_STEPS   = 4;
   localparam int  CNT_W           = 16;
   // Least time: rounded up
   localparam int  SQ_DELAY_CYC_I  =
      int'($ceil(SQ_DELAY_US * real'(CLK_HZ) / 1.0e6));
   // Timer step: period rounded down, at least one cycle
   localparam int  MRT_STEP_CYC_I  =
      (int'($floor(real'(MRT_STEP_FC) * real'(CLK_HZ) / CARRIER_HZ)) < 1)
      ? 1 : int'($floor(real'(MRT_STEP_FC) * real'(CLK_HZ) / CARRIER_HZ));
   localparam logic [CNT_W-1:0] SQ_DELAY_CYC = CNT_W'(SQ_DELAY_CYC_I);
   localparam logic [CNT_W-1:0] MRT_STEP_CYC = CNT_W'(MRT_STEP_CYC_I);
   localparam logic [7:0]       MRT_MIN     = 8'(MRT_MIN_STEPS);
   localparam logic [CNT_W-1:0] CNT_ONE     = 16'h0001;
   localparam logic [CNT_W-1:0] CNT_ZERO    = 16'h0000;

   // ****************************************
   // Squelch sequencer
   // ****************************************
   typedef enum logic [2:0] {
      SQ_IDLE   = 3'b001,
      SQ_DELAY  = 3'b010,
      SQ_ACTIVE = 3'b100
   } rxcfg_sq_state_type;

endpackage : rxcfg_pkg

// file: rxcfg_regs.sv
`timescale 1ns/1ns
// Contract
// - Receive-without-CRC bit skips CRC check
// - REQA, WUPA, anticollision always skip CRC
// - CRC-to-FIFO bit keeps CRC bytes; output forced off while CRC check is off
// - Modulation bit: OOK or AM, preset sets
// - Enable external field detector
// - Tristate drivers during OOK keying
// - Tolerant decoder bit, default one
// - Two bits give field-on n
// - Channel bit picks single enabled channel
// - Manual mode: channel bit feeds framing
// - AM demodulator peak or mixer
// - Lowpass and zero-setting codes to filter
// - Receiver low-power mode bit
// - LF inputs differential or split
// - Route LF signal onto receiver
// - AGC window eight pulses or whole
// - AGC algorithm preset or reset
// - Auto squelch after delay until mask
// - PM mixer clock source select
// - Defaults at reset and set-default
// - Mask timer steps of 64 carrier periods
module rxcfg_regs (
   input  wire logic                         core_clk_in,
   input  wire logic                         rst_b_in,
   input  wire logic                         wr_en_in,
   input  wire logic                         rd_en_in,
   input  wire logic [rxcfg_pkg::ADDR_W-1:0] addr_in,
   input  wire logic [7:0]                   wr_data_in,
   input  wire logic                         set_default_in,
   input  wire logic                         analog_preset_in,
   input  wire logic                         preset_am_in,
   input  wire logic                         auto_no_crc_frame_in,
   input  wire logic                         ook_keying_in,
   input  wire logic                         am_enabled_in,
   input  wire logic                         pm_enabled_in,
   input  wire logic                         manual_channel_in,
   input  wire logic                         single_ended_in,
   input  wire logic                         tx_end_in,
   input  wire logic [7:0]                   mask_timer_in,
   output logic [7:0]                        rd_data_out,
   output rxcfg_pkg::rxcfg_aux_type          aux_cfg_out,
   output rxcfg_pkg::rxcfg_rx1_type          rx1_cfg_out,
   output rxcfg_pkg::rxcfg_rx2_type          rx2_cfg_out,
   output logic                              crc_check_out,
   output logic                              crc_to_fifo_out,
   output logic                              driver_tristate_out,
   output logic                              ext_field_detect_out,
   output logic [1:0]                        field_on_n_out,
   output logic                              am_channel_on_out,
   output logic                              pm_channel_on_out,
   output logic                              framing_from_pm_out,
   output logic                              pm_mix_internal_out,
   output logic                              squelch_active_out
);
   import rxcfg_pkg::*;

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      rxcfg_aux_type       aux;
      rxcfg_rx1_type       rx1;
      rxcfg_rx2_type       rx2;
      logic [7:0]          rd_data;
      logic                crc_check;
      logic                crc_to_fifo;
      logic                tristate;
      logic                ext_fd;
      logic [1:0]          field_n;
      logic                am_on;
      logic                pm_on;
      logic                framing_pm;
      logic                pm_mix_int;
      logic                squelch;
      rxcfg_sq_state_type  sq_state;
      logic [CNT_W-1:0]    delay_cnt;
      logic [CNT_W-1:0]    mask_cnt;
   } rxcfg_state_type;

   localparam rxcfg_state_type STATE_RESET = '{
      aux:         AUX_DEFAULT,
      rx1:         RX1_DEFAULT,
      rx2:         RX2_DEFAULT,
      rd_data:     UNMAPPED_VAL,
      crc_check:   1'b1,
      crc_to_fifo: 1'b0,
      tristate:    1'b0,
      ext_fd:      1'b0,
      field_n:     2'b00,
      am_on:       1'b0,
      pm_on:       1'b0,
      framing_pm:  1'b0,
      pm_mix_int:  1'b0,
      squelch:     1'b0,
      sq_state:    SQ_IDLE,
      delay_cnt:   CNT_ZERO,
      mask_cnt:    CNT_ZERO
   };

   rxcfg_state_type state_reg;
   rxcfg_state_type state_next;
   logic [7:0]       mrt_steps;
   logic [CNT_W-1:0] mask_total;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      state_next = state_reg;
      mrt_steps  = (mask_timer_in < MRT_MIN) ? MRT_MIN : mask_timer_in;
      mask_total = CNT_W'(mrt_steps * MRT_STEP_CYC);

      if (analog_preset_in) begin
         state_next.aux.tx_modulation_select = preset_am_in;
      end
      if (wr_en_in) begin
         unique case (addr_in)
            AUX_DEF_ADDR: state_next.aux = rxcfg_aux_type'(wr_data_in);
            RX_CFG1_ADDR: state_next.rx1 = rxcfg_rx1_type'(wr_data_in);
            RX_CFG2_ADDR: state_next.rx2 = rxcfg_rx2_type'(wr_data_in);
            default: begin
            end
         endcase
      end
      if (set_default_in) begin
         state_next.aux = AUX_DEFAULT;
         state_next.rx1 = RX1_DEFAULT;
         state_next.rx2 = RX2_DEFAULT;
      end

      if (rd_en_in) begin
         unique case (addr_in)
            AUX_DEF_ADDR: state_next.rd_data = state_reg.aux;
            RX_CFG1_ADDR: state_next.rd_data = state_reg.rx1;
            RX_CFG2_ADDR: state_next.rd_data = state_reg.rx2;
            default:      state_next.rd_data = UNMAPPED_VAL;
         endcase
      end

      state_next.crc_check = !(state_reg.aux.rx_without_crc ||
                               auto_no_crc_frame_in);
      state_next.crc_to_fifo = state_reg.aux.crc_into_fifo &&
                               !state_next.crc_check ? 1'b0 :
                               state_reg.aux.crc_into_fifo;
      state_next.tristate = state_reg.aux.driver_tristate_on_keying &&
                            !state_reg.aux.tx_modulation_select &&
                            ook_keying_in;
      state_next.ext_fd  = state_reg.aux.ext_field_detect_enable;
      state_next.field_n = {state_reg.aux.field_on_n_hi,
                            state_reg.aux.field_on_n_lo};

      if (am_enabled_in && pm_enabled_in) begin
         state_next.am_on      = 1'b1;
         state_next.pm_on      = 1'b1;
         state_next.framing_pm = manual_channel_in ?
                                 state_reg.rx1.rx_channel_select :
                                 state_reg.framing_pm;
      end else if (am_enabled_in || pm_enabled_in) begin
         state_next.am_on      = !state_reg.rx1.rx_channel_select;
         state_next.pm_on      = state_reg.rx1.rx_channel_select;
         state_next.framing_pm = state_reg.rx1.rx_channel_select;
      end else begin
         state_next.am_on      = 1'b0;
         state_next.pm_on      = 1'b0;
         state_next.framing_pm = state_reg.framing_pm;
      end
      state_next.pm_mix_int = single_ended_in ||
                              state_reg.rx2.pm_mixer_clock_source;

      if (state_reg.mask_cnt != CNT_ZERO) begin
         state_next.mask_cnt = state_reg.mask_cnt - CNT_ONE;
      end
      unique case (state_reg.sq_state)
         SQ_IDLE: begin
            if (tx_end_in && state_reg.rx2.auto_squelch) begin
               state_next.sq_state  = SQ_DELAY;
               state_next.delay_cnt = SQ_DELAY_CYC;
               state_next.mask_cnt  = mask_total;
            end
         end
         SQ_DELAY: begin
            if (state_reg.mask_cnt <= CNT_ONE) begin
               state_next.sq_state = SQ_IDLE;
            end else if (state_reg.delay_cnt <= CNT_ONE) begin
               state_next.sq_state = SQ_ACTIVE;
               state_next.squelch  = 1'b1;
            end else begin
               state_next.delay_cnt = state_reg.delay_cnt - CNT_ONE;
            end
         end
         SQ_ACTIVE: begin
            if (state_reg.mask_cnt <= CNT_ONE) begin
               state_next.sq_state = SQ_IDLE;
               state_next.squelch  = 1'b0;
            end
         end
      endcase
      if (!state_next.rx2.auto_squelch) begin
         state_next.sq_state = SQ_IDLE;
         state_next.squelch  = 1'b0;
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   // power-up defaults
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_reg <= STATE_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // field outputs
   assign aux_cfg_out          = state_reg.aux;
   assign rx1_cfg_out          = state_reg.rx1;
   assign rx2_cfg_out          = state_reg.rx2;
   assign rd_data_out          = state_reg.rd_data;
   assign crc_check_out        = state_reg.crc_check;
   assign crc_to_fifo_out      = state_reg.crc_to_fifo;
   assign driver_tristate_out  = state_reg.tristate;
   assign ext_field_detect_out = state_reg.ext_fd;
   assign field_on_n_out       = state_reg.field_n;
   assign am_channel_on_out    = state_reg.am_on;
   assign pm_channel_on_out    = state_reg.pm_on;
   assign framing_from_pm_out  = state_reg.framing_pm;
   assign pm_mix_internal_out  = state_reg.pm_mix_int;
   assign squelch_active_out   = state_reg.squelch;

endmodule : rxcfg_regs

// file: rxcfg_regs_chk.sv
`timescale 1ns/1ns
module rxcfg_regs_chk (
   input wire logic                         core_clk_in,
   input wire logic                         rst_b_in,
   input wire logic                         wr_en_in,
   input wire logic                         rd_en_in,
   input wire logic [rxcfg_pkg::ADDR_W-1:0] addr_in,
   input wire logic [7:0]                   wr_data_in,
   input wire logic                         set_default_in,
   input wire logic                         analog_preset_in,
   input wire logic                         preset_am_in,
   input wire logic                         auto_no_crc_frame_in,
   input wire logic                         ook_keying_in,
   input wire logic                         single_ended_in,
   input wire logic                         tx_end_in,
   input wire logic [7:0]                   rd_data_out,
   input wire rxcfg_pkg::rxcfg_aux_type     aux_cfg_out,
   input wire rxcfg_pkg::rxcfg_rx2_type     rx2_cfg_out,
   input wire logic                         crc_check_out,
   input wire logic                         crc_to_fifo_out,
   input wire logic                         driver_tristate_out,
   input wire logic [1:0]                   field_on_n_out,
   input wire logic                         pm_mix_internal_out,
   input wire logic                         squelch_active_out
);
   import rxcfg_pkg::*;
   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_b_in);
   write_lands_a: assert property (wr_en_in && !set_default_in &&
      addr_in == AUX_DEF_ADDR |=> aux_cfg_out == $past(wr_data_in))
      else $error("aux write not stored");
   unmapped_read_a: assert property (rd_en_in && addr_in < 6'h09
      |=> rd_data_out == UNMAPPED_VAL) else $error("unmapped read not zero");
   default_load_a: assert property (set_default_in |=>
      aux_cfg_out == AUX_DEFAULT && rx2_cfg_out == RX2_DEFAULT)
      else $error("defaults not loaded");
   crc_skip_a: assert property ($past(rst_b_in) |-> crc_check_out ==
      !$past(aux_cfg_out.rx_without_crc | auto_no_crc_frame_in))
      else $error("crc check wrong");
   crc_fifo_a: assert property (crc_to_fifo_out |-> crc_check_out)
      else $error("crc to fifo without check");
   tristate_a: assert property ($past(rst_b_in) |-> driver_tristate_out ==
      $past(aux_cfg_out.driver_tristate_on_keying & ook_keying_in
      & !aux_cfg_out.tx_modulation_select)) else $error("tristate wrong");
   field_n_a: assert property ($past(rst_b_in) |->
      field_on_n_out == $past(aux_cfg_out[1:0])) else $error("n wrong");
   preset_mod_a: assert property (analog_preset_in && !wr_en_in &&
      !set_default_in |=> aux_cfg_out.tx_modulation_select == $past(preset_am_in))
      else $error("preset modulation wrong");
   pm_mix_a: assert property ($past(rst_b_in) |-> pm_mix_internal_out ==
      $past(single_ended_in | rx2_cfg_out.pm_mixer_clock_source))
      else $error("mixer clock wrong");
   squelch_en_a: assert property ($rose(squelch_active_out) |->
      $past(rx2_cfg_out.auto_squelch)) else $error("squelch while off");
   write_c: cover property (wr_en_in);
   squelch_c: cover property ($rose(squelch_active_out));
   default_c: cover property (set_default_in);
endmodule : rxcfg_regs_chk
bind rxcfg_regs rxcfg_regs_chk u_chk (.*);

// file: rxcfg_regs_tb.sv
`timescale 1ns/1ns
module rxcfg_regs_tb;
   import rxcfg_pkg::*;
   logic clk = 1'b0, rst_b = 1'b0, wr_en = 1'b0, rd_en = 1'b0, sd = 1'b0;
   logic ap = 1'b0, pam = 1'b0, anc = 1'b0, ook = 1'b0, am = 1'b0;
   logic pm = 1'b0, man = 1'b0, se = 1'b0, txe = 1'b0;
   logic [5:0] addr = 6'h00;
   logic [7:0] wd = 8'h00, mask = 8'h0A, rd;
   rxcfg_aux_type aux;
   rxcfg_rx1_type rx1;
   rxcfg_rx2_type rx2;
   logic crc, fifo, tri_o, efd, amo, pmo, frm, pmx, sq;
   logic [1:0] fn;
   int mismatches = 0, comparisons = 0, cycles = 0;
   rxcfg_regs dut (.core_clk_in(clk), .rst_b_in(rst_b), .wr_en_in(wr_en),
      .rd_en_in(rd_en), .addr_in(addr), .wr_data_in(wd),
      .set_default_in(sd), .analog_preset_in(ap), .preset_am_in(pam),
      .auto_no_crc_frame_in(anc), .ook_keying_in(ook), .am_enabled_in(am),
      .pm_enabled_in(pm), .manual_channel_in(man), .single_ended_in(se),
      .tx_end_in(txe), .mask_timer_in(mask), .rd_data_out(rd),
      .aux_cfg_out(aux), .rx1_cfg_out(rx1), .rx2_cfg_out(rx2),
      .crc_check_out(crc), .crc_to_fifo_out(fifo),
      .driver_tristate_out(tri_o), .ext_field_detect_out(efd),
      .field_on_n_out(fn), .am_channel_on_out(amo), .pm_channel_on_out(pmo),
      .framing_from_pm_out(frm), .pm_mix_internal_out(pmx),
      .squelch_active_out(sq));
   // ****************************************
   // Clock, timeout and tasks
   // ****************************************
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         finish_test();
      end
   end
   task automatic finish_test;
      $display("checks %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : finish_test
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      wr_en <= 1'b1;
      addr  <= a;
      wd    <= d;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask : wr
   task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
      @(posedge clk);
      rd_en <= 1'b1;
      addr  <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 chk("rd_data", e, rd);
   endtask : rd_chk
   task automatic defaults_chk;
      rd_chk(AUX_DEF_ADDR, 8'h04);
      rd_chk(RX_CFG1_ADDR, 8'h00);
      rd_chk(RX_CFG2_ADDR, 8'h1A);
   endtask : defaults_chk
   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      defaults_chk();
      rd_chk(6'h08, 8'h00);
      for (int i = 0; i < 3; i++) begin
         wr(AUX_DEF_ADDR + 6'(i), 8'hA5 ^ 8'(i));
         wr(AUX_DEF_ADDR + 6'(i), 8'h5A ^ 8'(i));
         rd_chk(AUX_DEF_ADDR + 6'(i), 8'h5A ^ 8'(i));
      end
      @(posedge clk) sd <= 1'b1;
      @(posedge clk) sd <= 1'b0;
      defaults_chk();
      wr(AUX_DEF_ADDR, 8'h80);
      tick(2);
      chk("crc_check", 8'h00, crc);
      wr(AUX_DEF_ADDR, 8'h40);
      tick(2);
      chk("crc_fifo", 8'h01, fifo);
      @(posedge clk) anc <= 1'b1;
      tick(2);
      chk("crc_auto", 8'h00, crc);
      chk("fifo_off", 8'h00, fifo);
      @(posedge clk) anc <= 1'b0;
      wr(AUX_DEF_ADDR, 8'h1B);
      ook <= 1'b1;
      tick(2);
      chk("tristate", 8'h01, tri_o);
      chk("field_n", 8'h03, fn);
      chk("ext_fd", 8'h01, efd);
      @(posedge clk) pam <= 1'b1;
      ap <= 1'b1;
      @(posedge clk) ap <= 1'b0;
      tick(2);
      chk("tristate_am", 8'h00, tri_o);
      chk("tx_mod", 8'h01, aux.tx_modulation_select);
      wr(RX_CFG1_ADDR, 8'h80);
      am <= 1'b1;
      se <= 1'b1;
      tick(2);
      chk("pm_single", 8'h01, pmo);
      chk("am_off", 8'h00, amo);
      chk("pm_mix", 8'h01, pmx);
      @(posedge clk) pm <= 1'b1;
      man <= 1'b1;
      tick(2);
      chk("am_both", 8'h01, amo);
      chk("pm_both", 8'h01, pmo);
      chk("framing_pm", 8'h01, frm);
      wr(RX_CFG1_ADDR, 8'h00);
      tick(2);
      chk("framing_am", 8'h00, frm);
      @(posedge clk) txe <= 1'b1;
      @(posedge clk) txe <= 1'b0;
      tick(184);
      chk("sq_early", 8'h00, sq);
      tick(10);
      chk("sq_on", 8'h01, sq);
      tick(285);
      chk("sq_end", 8'h00, sq);
      @(posedge clk) mask <= 8'h05;
      @(posedge clk) txe <= 1'b1;
      @(posedge clk) txe <= 1'b0;
      tick(194);
      chk("sq_on_short", 8'h01, sq);
      tick(40);
      chk("sq_hold_short", 8'h01, sq);
      tick(1);
      chk("sq_end_short", 8'h00, sq);
      @(posedge clk) se <= 1'b0;
      tick(2);
      chk("pm_mix_off", 8'h00, pmx);
      wr(RX_CFG1_ADDR, 8'h7F);
      wr(RX_CFG2_ADDR, 8'hE5);
      tick(2);
      chk("rx1_cfg", 8'h7F, rx1);
      chk("rx2_cfg", 8'hE5, rx2);
      chk("pm_mix_rx2", 8'h01, pmx);
      finish_test();
   end
endmodule : rxcfg_regs_tb
